// [hdl/fts_consts.vh]
`ifndef FTS_CONSTS_VH
`define FTS_CONSTS_VH
// register byte addresses
`define FTS_REG_CTRL 12'h000
`define FTS_REG_FRAME_LEN 12'h004
`define FTS_REG_LINE_LEN 12'h008
`define FTS_REG_EXTRA 12'h00c
`define FTS_REG_STATUS 12'h010
`define FTS_REG_WIDTH 12'h014
`define FTS_REG_ODD_INC 12'h018
`define FTS_REG_ROWLIM 12'h01c
// control fields
`define FTS_CTL_GENERAL_INPUT_ENABLE 8
`define FTS_CTL_TRIG_FOLLOW 4
`define FTS_CTL_EMB_EN 9
`define FTS_CTL_DARK_LSB 12
`define FTS_CTL_DARK_MSB 15
`define FTS_CTL_PROTO_LSB 16
`define FTS_CTL_PROTO_MSB 18
`define FTS_CTL_RESET 32'h0000_8200
// dark reference codes
`define FTS_DARK_8 4'h8
`define FTS_DARK_4 4'h4
`define FTS_DARK_2 4'h2
`define FTS_EMB_ROWS 16'h0002
`define FTS_BLANK_ROWS 16'h0002
// protocols
`define FTS_PROTO_PAR 3'h0
`define FTS_PROTO_SS 3'h1
`define FTS_PROTO_SSP 3'h2
`define FTS_PROTO_PSP 3'h3
`define FTS_PROTO_MIPI 3'h4
// row kinds
`define FTS_ROW_DARK 2'h0
`define FTS_ROW_EMB 2'h1
`define FTS_ROW_BLANK 2'h2
`define FTS_ROW_ACTIVE 2'h3
// sync marker bits
`define FTS_MK_SOV 0
`define FTS_MK_SOF 1
`define FTS_MK_SOA 2
`define FTS_MK_EOL 3
`define FTS_MK_EOF 4
// timing
`define FTS_TRIG_GUARD 32'd16
`define FTS_OUT_EXTRA 16'd96
`define FTS_FRAME_RESET 16'd1320
`define FTS_LINE_RESET 16'd1242
`define FTS_WIDTH_RESET 16'd2303
`define FTS_ODD_RESET 16'd1
`define FTS_ROWLIM_RESET 16'd1242
`endif

// [hdl/fts_buf2.v]
`timescale 1ns/100ps
`include "fts_consts.vh"
module fts_buf2 #(
   parameter W = 8
)(
   input wire aclk, // clock
   input wire aresetn, // sync reset, low
   input wire [W-1:0] in_data, // word in
   input wire in_valid, // word offered
   output wire in_ready, // room free
   output reg [W-1:0] out_data, // head word
   output wire out_valid, // head valid
   input wire out_ready // consumer takes
);
   reg [W-1:0] mem [0:1];
   reg [1:0] cnt;
   reg rd;
   reg wr;
   wire push;
   wire pop;
   assign in_ready = (cnt != 2'd2);
   assign out_valid = (cnt != 2'd0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @*
   begin
      out_data = mem[rd];
   end
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt <= 2'd0;
         rd <= 1'b0;
         wr <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            mem[wr] <= in_data;
            wr <= ~wr;
         end
         if (pop)
            rd <= ~rd;
         cnt <= cnt + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// [hdl/fts_axil.v]
`timescale 1ns/100ps
`include "fts_consts.vh"
module fts_axil (
   input wire aclk, // clock
   input wire aresetn, // sync reset, low
   input wire [11:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // aw valid
   output wire s_axi_awready, // aw ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // w valid
   output wire s_axi_wready, // w ready
   output reg [1:0] s_axi_bresp, // write resp
   output reg s_axi_bvalid, // b valid
   input wire s_axi_bready, // b ready
   input wire [11:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // ar valid
   output wire s_axi_arready, // ar ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read resp
   output reg s_axi_rvalid, // r valid
   input wire s_axi_rready, // r ready
   output reg [31:0] ctrl, // control word
   output reg [15:0] frame_len, // rows per frame
   output reg [15:0] line_len, // clocks per row
   output reg [31:0] extra_delay, // clocks between frames
   output reg [15:0] width_span, // x end minus start
   output reg [15:0] odd_inc, // x odd increment
   output reg [15:0] adc_limit, // adc row limit
   input wire [31:0] status // block state
);
   reg aw_hold;
   reg w_hold;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (st[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction
   // 16-bit registers only take the two low byte lanes
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] nw;
      input [3:0] st;
      begin
         merge16[15:8] = st[1] ? nw[15:8] : old[15:8];
         merge16[7:0] = st[0] ? nw[7:0] : old[7:0];
      end
   endfunction
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         ctrl <= `FTS_CTL_RESET;
         frame_len <= `FTS_FRAME_RESET;
         line_len <= `FTS_LINE_RESET;
         extra_delay <= 32'h0000_0000;
         width_span <= `FTS_WIDTH_RESET;
         odd_inc <= `FTS_ODD_RESET;
         adc_limit <= `FTS_ROWLIM_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_hold && w_hold)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (aw_addr)
               `FTS_REG_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
               `FTS_REG_FRAME_LEN:
                  frame_len <= merge16(frame_len, w_data, w_strb);
               `FTS_REG_LINE_LEN:
                  line_len <= merge16(line_len, w_data, w_strb);
               `FTS_REG_EXTRA:
                  extra_delay <= merge(extra_delay, w_data, w_strb);
               `FTS_REG_WIDTH:
                  width_span <= merge16(width_span, w_data, w_strb);
               `FTS_REG_ODD_INC:
                  odd_inc <= merge16(odd_inc, w_data, w_strb);
               `FTS_REG_ROWLIM:
                  adc_limit <= merge16(adc_limit, w_data, w_strb);
               `FTS_REG_STATUS: s_axi_bresp <= 2'h0;
               default: s_axi_bresp <= 2'h2;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `FTS_REG_CTRL: s_axi_rdata <= ctrl;
               `FTS_REG_FRAME_LEN: s_axi_rdata <= {16'h0000, frame_len};
               `FTS_REG_LINE_LEN: s_axi_rdata <= {16'h0000, line_len};
               `FTS_REG_EXTRA: s_axi_rdata <= extra_delay;
               `FTS_REG_STATUS: s_axi_rdata <= status;
               `FTS_REG_WIDTH: s_axi_rdata <= {16'h0000, width_span};
               `FTS_REG_ODD_INC: s_axi_rdata <= {16'h0000, odd_inc};
               `FTS_REG_ROWLIM: s_axi_rdata <= {16'h0000, adc_limit};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [hdl/fts_frame_timing.v]
`timescale 1ns/100ps
`include "fts_consts.vh"
// Contract
// - frame length is a row count including active and blanking rows
// - minimum blanking is dark rows plus two embedded plus two blank
// - dark code 8, 4 or 2 gives blanking 12, 8 or 6
// - embedded enable set emits two info rows, clear emits blank rows
// - trigger mode needs input enable and trigger-follow both set
// - without trigger mode, next frame starts after extra delay
// - while waiting, a vertical-drive rising edge starts the frame
// - after a trigger, deaf for one frame period minus 16 clocks
// - while waiting, shutter and read pointers are paused
// - a rising edge outside the waiting state is ignored
// - each frame outputs blanking rows first, then active rows
// - sync markers per protocol; parallel uses frame and line valid
// - minimum row length is the largest of three limits
// - frame period is rows times row length plus extra delay
module fts_frame_timing (
   input wire aclk, // pixel clock, 25 MHz
   input wire aresetn, // sync reset, low
   input wire [11:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // aw valid
   output wire s_axi_awready, // aw ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // w valid
   output wire s_axi_wready, // w ready
   output wire [1:0] s_axi_bresp, // write resp
   output wire s_axi_bvalid, // b valid
   input wire s_axi_bready, // b ready
   input wire [11:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // ar valid
   output wire s_axi_arready, // ar ready
   output wire [31:0] s_axi_rdata, // read data
   output wire [1:0] s_axi_rresp, // read resp
   output wire s_axi_rvalid, // r valid
   input wire s_axi_rready, // r ready
   input wire vertical_drive_trigger, // trigger pin, async
   output reg frame_valid_out, // parallel frame valid
   output reg line_valid_out, // parallel line valid
   output reg [1:0] row_kind, // kind of current row
   output reg [15:0] row_index, // row within frame
   output reg pointers_run, // shutter and read advance
   output wire [4:0] sync_marker, // marker set, buffered
   output wire sync_valid, // marker word valid
   input wire sync_ready // marker consumer ready
);
   localparam ST_DELAY = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_READ = 2'h2;
   wire [31:0] ctrl;
   wire [15:0] frame_len;
   wire [15:0] line_len;
   wire [31:0] extra_delay;
   wire [15:0] width_span;
   wire [15:0] odd_inc;
   wire [15:0] adc_limit;
   wire [31:0] status;
   reg [1:0] state;
   reg [15:0] pix_cnt;
   reg [31:0] delay_cnt;
   reg [31:0] deaf_cnt;
   reg trig_s1;
   reg trig_s2;
   reg trig_d;
   reg trig_armed;
   reg [15:0] dark_rows;
   reg [15:0] min_blank;
   reg [15:0] eff_frame;
   reg [15:0] row_len;
   reg [15:0] lim_dig;
   reg [15:0] lim_out;
   reg [15:0] sub;
   reg [16:0] sub_wide;
   reg [31:0] frame_clocks;
   reg [4:0] next_marker;
   reg mk_push;
   wire mk_ready;
   wire trig_mode;
   wire trig_rise;
   wire [2:0] proto;
   wire row_end;
   wire frame_end;
   //--------------------------------------------------
   // register slave
   //--------------------------------------------------
   fts_axil u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .ctrl(ctrl),
      .frame_len(frame_len),
      .line_len(line_len),
      .extra_delay(extra_delay),
      .width_span(width_span),
      .odd_inc(odd_inc),
      .adc_limit(adc_limit),
      .status(status)
   );
   //--------------------------------------------------
   // configuration decode
   //--------------------------------------------------
   assign trig_mode = ctrl[`FTS_CTL_GENERAL_INPUT_ENABLE]
      && ctrl[`FTS_CTL_TRIG_FOLLOW];
   assign proto = ctrl[`FTS_CTL_PROTO_MSB:`FTS_CTL_PROTO_LSB];
   always @*
   begin
      case (ctrl[`FTS_CTL_DARK_MSB:`FTS_CTL_DARK_LSB])
         `FTS_DARK_4: dark_rows = 16'd4;
         `FTS_DARK_2: dark_rows = 16'd2;
         default: dark_rows = 16'd8;
      endcase
      min_blank = dark_rows + `FTS_EMB_ROWS + `FTS_BLANK_ROWS;
      // a short frame still carries its blanking rows
      eff_frame = (frame_len > min_blank) ? frame_len : min_blank;
      // x span over subsample factor, i.e. 2*span/(inc+1), or span itself when inc is 0
      sub_wide = (odd_inc == 16'd0) ? {1'b0, width_span}
         : (({width_span, 1'b0}) / ({1'b0, odd_inc} + 17'd1));
      sub = sub_wide[15:0];
      lim_dig = sub / 16'd3;
      lim_out = (sub >> 1) + `FTS_OUT_EXTRA;
      row_len = adc_limit;
      if (lim_dig > row_len)
         row_len = lim_dig;
      if (lim_out > row_len)
         row_len = lim_out;
      if (line_len > row_len)
         row_len = line_len;
      frame_clocks = eff_frame * row_len + extra_delay;
   end
   //--------------------------------------------------
   // trigger input
   //--------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_d <= 1'b0;
      end
      else
      begin
         trig_s1 <= vertical_drive_trigger;
         trig_s2 <= trig_s1;
         trig_d <= trig_s2;
      end
   end
   assign trig_rise = trig_s2 && !trig_d;
   //--------------------------------------------------
   // sequencer
   //--------------------------------------------------
   assign row_end = (state == ST_READ) && (pix_cnt == row_len - 16'd1);
   assign frame_end = row_end && (row_index == eff_frame - 16'd1);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_DELAY;
         pix_cnt <= 16'h0000;
         row_index <= 16'h0000;
         delay_cnt <= 32'h0000_0000;
         deaf_cnt <= 32'h0000_0000;
         trig_armed <= 1'b0;
      end
      else
      begin
         // deaf window runs in parallel with the readout
         if (deaf_cnt != 32'h0000_0000)
            deaf_cnt <= deaf_cnt - 32'd1;
         else if (trig_mode)
            trig_armed <= 1'b1;
         case (state)
            ST_DELAY:
            begin
               if (trig_mode)
               begin
                  state <= ST_WAIT;
                  delay_cnt <= 32'h0000_0000;
               end
               else if (delay_cnt + 32'd1 >= extra_delay)
               begin
                  state <= ST_READ;
                  delay_cnt <= 32'h0000_0000;
               end
               else
                  delay_cnt <= delay_cnt + 32'd1;
            end
            ST_WAIT:
            begin
               // row and pixel counters hold here, pointers stand still
               if (!trig_mode)
                  state <= ST_DELAY;
               else if (trig_rise && trig_armed && deaf_cnt == 32'd0)
               begin
                  state <= ST_READ;
                  trig_armed <= 1'b0;
                  deaf_cnt <= (frame_clocks > `FTS_TRIG_GUARD)
                     ? frame_clocks - `FTS_TRIG_GUARD : 32'd0;
               end
            end
            ST_READ:
            begin
               if (row_end)
               begin
                  pix_cnt <= 16'h0000;
                  if (frame_end)
                  begin
                     row_index <= 16'h0000;
                     // outside trigger mode, no idle cycle when no extra delay is set
                     if (trig_mode)
                        state <= ST_WAIT;
                     else if (extra_delay == 32'h0000_0000)
                        state <= ST_READ;
                     else
                        state <= ST_DELAY;
                  end
                  else
                     row_index <= row_index + 16'd1;
               end
               else
                  pix_cnt <= pix_cnt + 16'd1;
            end
            default: state <= ST_DELAY;
         endcase
         // edges while deaf or reading are dropped, not queued:
         // only the waiting state looks at trig_rise
      end
   end
   //--------------------------------------------------
   // row kind and outputs
   //--------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         row_kind <= `FTS_ROW_DARK;
         frame_valid_out <= 1'b0;
         line_valid_out <= 1'b0;
         pointers_run <= 1'b0;
      end
      else
      begin
         pointers_run <= (state == ST_READ);
         frame_valid_out <= (state == ST_READ) && (row_index >= min_blank);
         line_valid_out <= (state == ST_READ) && (row_index >= min_blank)
            && (pix_cnt < row_len - `FTS_OUT_EXTRA);
         if (row_index < dark_rows)
            row_kind <= `FTS_ROW_DARK;
         else if (row_index < dark_rows + `FTS_EMB_ROWS)
            row_kind <= ctrl[`FTS_CTL_EMB_EN]
               ? `FTS_ROW_EMB : `FTS_ROW_BLANK;
         else if (row_index < min_blank)
            row_kind <= `FTS_ROW_BLANK;
         else
            row_kind <= `FTS_ROW_ACTIVE;
      end
   end
   //--------------------------------------------------
   // sync markers
   //--------------------------------------------------
   always @*
   begin
      next_marker = 5'h00;
      mk_push = 1'b0;
      if (state == ST_READ && pix_cnt == 16'h0000 && proto != `FTS_PROTO_PAR)
      begin
         mk_push = 1'b1;
         if (row_index < min_blank)
         begin
            if (proto == `FTS_PROTO_SSP || proto == `FTS_PROTO_SS)
               next_marker[`FTS_MK_SOV] = 1'b1;
         end
         else
            next_marker[`FTS_MK_SOA] = 1'b1;
         if (row_index == 16'h0000 && proto != `FTS_PROTO_SS)
            next_marker[`FTS_MK_SOF] = 1'b1;
      end
      else if (row_end && proto != `FTS_PROTO_PAR && proto != `FTS_PROTO_SS)
      begin
         mk_push = 1'b1;
         next_marker[`FTS_MK_EOL] = 1'b1;
         if (frame_end)
            next_marker[`FTS_MK_EOF] = 1'b1;
      end
      // protocols without a blanking marker push nothing at blanking row starts after row 0
      mk_push = mk_push && (next_marker != 5'h00);
   end
   // a stalled consumer drops markers only after two are queued
   fts_buf2 #(.W(5)) u_mk (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data(next_marker),
      .in_valid(mk_push),
      .in_ready(mk_ready),
      .out_data(sync_marker),
      .out_valid(sync_valid),
      .out_ready(sync_ready)
   );
   assign status = {13'h0000, !mk_ready, trig_armed, trig_mode,
      state == ST_WAIT, state == ST_READ, row_len[9:0], row_index[3:0]};
endmodule

// [sim/fts_checker_properties.sv]
`timescale 1ns/100ps
// --------------------------
// sequencer port checks
// --------------------------
module fts_checker (
   input wire aclk, // pixel clock
   input wire aresetn, // reset, low
   input wire s_axi_awvalid, // aw valid
   input wire s_axi_awready, // aw ready
   input wire s_axi_wvalid, // w valid
   input wire s_axi_wready, // w ready
   input wire s_axi_bvalid, // b valid
   input wire [1:0] row_kind, // row kind
   input wire [15:0] row_index, // row in frame
   input wire pointers_run, // readout runs
   input wire [4:0] sync_marker, // marker word
   input wire sync_valid, // marker valid
   input wire sync_ready // marker taken
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_new_row;
      $changed(row_index) && row_index != 16'h0000;
   endsequence
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   pause_hold_a: assert property (
      !pointers_run ##1 !pointers_run |-> $stable(row_index))
      else $error("row index moved while paused");
   row_step_a: assert property (
      s_new_row |-> row_index == $past(row_index) + 16'h0001)
      else $error("row index skipped");
   blank_first_a: assert property (
      $rose(pointers_run) |-> row_kind != 2'h3)
      else $error("frame opened with an active row");
   active_late_a: assert property (
      row_kind == 2'h3 |-> $past(row_index) >= 16'h0006)
      else $error("active row inside minimum blanking");
   kind_order_a: assert property (
      row_kind == 2'h3 ##1 s_new_row |-> row_kind == 2'h3)
      else $error("blanking row after active rows");
   buf_hold_a: assert property (
      sync_valid && !sync_ready |=> sync_valid && $stable(sync_marker))
      else $error("marker lost during stall");
   marker_set_a: assert property (
      sync_valid |-> sync_marker != 5'h00)
      else $error("empty marker word");
   b_timely_a: assert property (
      s_wr_both |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
endmodule
bind fts_frame_timing fts_checker chk_i (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .row_kind, .row_index, .pointers_run, .sync_marker, .sync_valid,
   .sync_ready);

// [sim/fts_vd_model.sv]
`timescale 1ns/100ps
// --------------------------
// vertical-drive source
// --------------------------
module fts_vd_model (
   input wire aclk, // pixel clock
   input wire aresetn, // sync reset, low
   input wire [31:0] period, // pulse spacing
   input wire [31:0] stray, // offset of an extra pulse, 0 none
   output reg vertical_drive_trigger // trigger level
);
   reg [31:0] phase;
   // a steady period keeps the sensor's wait short and even
   always @(posedge aclk)
   begin
      if (!aresetn || period == 32'h0)
      begin
         phase <= 32'h0;
         vertical_drive_trigger <= 1'b0;
      end
      else
      begin
         phase <= (phase + 32'h1 >= period) ? 32'h0 : phase + 32'h1;
         vertical_drive_trigger <= (phase < 32'h4) || (stray != 32'h0 &&
            phase >= stray && phase < stray + 32'h4);
      end
   end
endmodule

// [sim/frame_timing_slave_trigger_tb_top.sv]
`timescale 1ns/100ps
// --------------------------
// sequencer bench
// --------------------------
module frame_timing_slave_trigger_tb_top;
   localparam [31:0] any = 32'hffff_ffff;
   reg aclk = 1'b0, aresetn = 1'b0, srdy = 1'b1;
   reg awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   reg [11:0] awa = 12'h000, ara = 12'h000;
   reg [31:0] wd = 32'h0, vper = 32'h0, vstr = 32'h0;
   wire aw_r, w_r, b_v, ar_r, r_v, fv, lv, prun, sv, vd;
   wire [1:0] b_rs, r_rs, kind;
   wire [31:0] rdat;
   wire [15:0] ridx;
   wire [4:0] mk;
   int miscompares = 0, samples_checked = 0;
   logic [11:0] ra [0:6] = '{12'h000, 12'h004, 12'h008, 12'h00c,
      12'h014, 12'h018, 12'h01c};
   logic [31:0] rv [0:6] = '{32'h8200, 32'h528, 32'h4da, 32'h0,
      32'h8ff, 32'h1, 32'h4da};
   always #20 aclk = ~aclk;
   fts_frame_timing dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_r),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(w_r), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(ar_r), .s_axi_rdata(rdat), .s_axi_rresp(r_rs),
      .s_axi_rvalid(r_v), .s_axi_rready(rre), .sync_ready(srdy),
      .vertical_drive_trigger(vd), .frame_valid_out(fv),
      .line_valid_out(lv), .row_kind(kind), .row_index(ridx),
      .pointers_run(prun), .sync_marker(mk), .sync_valid(sv));
   fts_vd_model vdm (.aclk(aclk), .aresetn(aresetn), .period(vper),
      .stray(vstr), .vertical_drive_trigger(vd));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task results;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one transfer at a time; each request held until its own ready
   task bus(input w, input [11:0] a, input [31:0] d,
      output [31:0] q, output [1:0] r);
      int n;
      {awa, ara, wd} <= {a, a, d};
      {awv, wv, bre} <= {3{w}};
      {arv, rre} <= {2{!w}};
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (aw_r) awv <= 1'b0;
         if (w_r) wv <= 1'b0;
         if (ar_r) arv <= 1'b0;
      end
      while (!(w ? b_v : r_v) && n < 200);
      if (n >= 200) miscompares++;
      q = rdat;
      r = w ? b_rs : r_rs;
      {bre, rre} <= 2'b00;
      @(posedge aclk);
   endtask
   // the third frame after a write is the one checked, the first may be mixed
   task run(input [31:0] c, ex, ec, eb, ee, ep, input [5:0] em);
      int cy, b, e, p;
      logic [5:0] m;
      logic chg;
      logic [31:0] q;
      logic [1:0] r;
      logic [15:0] pv;
      bus(1'b1, 12'h00c, ex, q, r);
      bus(1'b1, 12'h000, c, q, r);
      for (int k = 0; k < 2; k++)
      begin
         pv = ridx;
         while (!(ridx == 16'h0 && pv != 16'h0))
         begin
            pv = ridx;
            @(posedge aclk);
         end
         {cy, b, e, p, m, pv} = 150'h0;
         pv = 16'hffff;
         chg = 1'b0;
         do
         begin
            // row kind is registered, so it is read one cycle late
            if (chg && kind != 2'h3) b++;
            if (chg && kind == 2'h1) e++;
            chg = (ridx != pv);
            pv = ridx;
            p += !prun;
            if (sv && srdy) m[4:0] = m[4:0] | mk;
            m[5] = m[5] | fv;
            @(posedge aclk);
            cy++;
         end
         while (!(ridx == 16'h0 && pv != 16'h0));
      end
      chk("frame clocks", ec, cy);
      chk("blanking rows", eb, b);
      chk("embedded rows", ee, e);
      if (ep != any) chk("paused clocks", ep, p);
      chk("sync markers", {27'h0, em[4:0]}, {27'h0, m[4:0]});
      if (em[5]) chk("frame valid", 32'h1, {31'h0, m[5]});
   endtask
   initial
   begin
      logic [31:0] q;
      logic [1:0] r;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b0, ra[i], 32'h0, q, r);
         chk("register reset", rv[i], q);
      end
      bus(1'b0, 12'h020, 32'h0, q, r);
      chk("unmapped read", 32'h2, {30'h0, r});
      bus(1'b1, 12'h024, 32'h1, q, r);
      chk("unmapped write", 32'h2, {30'h0, r});
      bus(1'b1, 12'h004, 32'he, q, r);
      bus(1'b1, 12'h008, 32'h64, q, r);
      bus(1'b1, 12'h014, 32'h0, q, r);
      bus(1'b1, 12'h01c, 32'h0, q, r);
      bus(1'b0, 12'h008, 32'h0, q, r);
      chk("row length", 32'h64, q);
      run(32'h28200,32'h0,32'h578,32'hc,32'h2,any,6'h1f);
      run(32'h24200,32'h0,32'h578,32'h8,32'h2,any,6'h1f);
      run(32'h22000,32'h0,32'h578,32'h6,32'h0,any,6'h1f);
      run(32'h18200,32'h0,32'h578,32'hc,32'h2,any,6'h05);
      run(32'h38200,32'h0,32'h578,32'hc,32'h2,any,6'h1e);
      run(32'h48200,32'h0,32'h578,32'hc,32'h2,any,6'h1e);
      run(32'h08200,32'h0,32'h578,32'hc,32'h2,any,6'h20);
      run(32'h28200,32'hc8,32'h640,32'hc,32'h2,any,6'h1f);
      vper <= 32'h5dc;
      run(32'h28210,32'h0,32'h578,32'hc,32'h2,any,6'h1f);
      vper <= 32'h582;
      vstr <= 32'h2bc;
      run(32'h28310,32'h0,32'h582,32'hc,32'h2,32'ha,6'h1f);
      q[15:0] = ridx;
      while (ridx == q[15:0]) @(posedge aclk);
      repeat (10) @(posedge aclk);
      srdy <= 1'b0;
      repeat (150) @(posedge aclk);
      chk("held marker", 32'h1, {31'h0, sv});
      srdy <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("second entry", 32'h1, {31'h0, sv});
      @(posedge aclk);
      chk("drained buffer", 32'h0, {31'h0, sv});
      results;
   end
   initial
   begin
      repeat (32'h186a0) @(posedge aclk);
      miscompares++;
      results;
   end
endmodule
